//--- design/rid_consts.svh
`ifndef RID_CONSTS_SVH
`define RID_CONSTS_SVH

// Register addresses on the memory bus
`define RID_ADDR_DAY 17'h1FFF5
`define RID_ADDR_CTL 17'h1FFF6
`define RID_ADDR_FLG 17'h1FFE0

// Interrupt control fields
`define RID_CTL_WIE 7
`define RID_CTL_AIE 6
`define RID_CTL_POWERFAIL_IRQ_ENABLE 5
`define RID_CTL_HL 3
`define RID_CTL_PL 2
`define RID_CTL_WMASK 8'hEC
`define RID_CTL_RST 8'h00

// Day alarm fields
`define RID_DAY_MASK 7
`define RID_DAY_DATE_HI 5
`define RID_DAY_WMASK 8'hBF
`define RID_DAY_RST 8'h00

// Flag register fields
`define RID_FLG_WDF 7
`define RID_FLG_AF 6
`define RID_FLG_PF 5

// Pulse mode length in clock cycles
`define RID_PULSE_CYC 8'h08
`define RID_PULSE_ZERO 8'h00
`define RID_BYTE_ZERO 8'h00

`endif

//--- design/rid_pkg.sv
package rid_pkg;

	// Memory bus pins as one synchroniser stage
	typedef struct packed {
		logic ce_n;
		logic we_n;
		logic oe_n;
		logic [16:0] addr;
		logic [7:0] dq;
	} rid_bus_t;

	// Event inputs from the RTC time base logic
	typedef struct packed {
		logic wdog;
		logic alarm_tick;
		logic alarm_fields;
		logic pfail;
	} rid_evt_t;

	// Whole state of the controller
	typedef struct packed {
		rid_bus_t s1;
		rid_bus_t s2;
		logic we_prev;
		logic oe_prev;
		logic wpend;
		logic [16:0] wa;
		logic [7:0] wd;
		logic [16:0] ra;
		logic [7:0] ctl;
		logic [7:0] day;
		logic [7:0] rd;
		logic watchdog_flag;
		logic af;
		logic pf;
		logic pf_prev;
		logic [7:0] pcnt;
	} rid_state_t;

endpackage : rid_pkg

//--- design/rid_day_match.sv
`timescale 1ns/1ps
`include "rid_consts.svh"

module rid_day_match (
	// Compare register and current date
	input wire logic [7:0] day_reg_in,
	input wire logic [5:0] cur_date_in,
	// Result
	output logic hit_out
);

	// Mask bit set makes the date a don't-care
	assign hit_out = day_reg_in[`RID_DAY_MASK] ||
		(cur_date_in == day_reg_in[`RID_DAY_DATE_HI:0]); // R06

endmodule : rid_day_match

//--- design/rid_top.sv
`timescale 1ns/1ps
`include "rid_consts.svh"

// Contract
// R01: Watchdog timeout with its enable set raises the interrupt and sets its flag.
// R02: Watchdog timeout with its enable clear sets only the watchdog flag.
// R03: Alarm match with its enable set raises the interrupt and sets its flag.
// R04: Alarm match with its enable clear sets only the alarm flag.
// R05: Power-fail sets its flag; with its enable set it also drives the interrupt.
// R06: Day alarm top bit 0 compares the date, 1 ignores it.
// R07: Polarity bit 1 drives interrupt active high; 0 gives open-drain active low.
module rid_top (
	// Clock, reset, enable
	input wire logic sys_clk_in,
	input wire logic rst_n_in,
	input wire logic cke_in,
	// Asynchronous memory bus pins
	input wire logic mem_ce_n_in,
	input wire logic mem_we_n_in,
	input wire logic mem_oe_n_in,
	input wire logic [16:0] mem_addr_in,
	input wire logic [7:0] mem_dq_in,
	output logic [7:0] mem_dq_out,
	output logic mem_dq_oe_out,
	// Events and current date from the RTC
	input wire rid_pkg::rid_evt_t evt_in,
	input wire logic [5:0] cur_date_in,
	// Interrupt pin
	output logic irq_pin_out,
	output logic irq_pin_oe_out
);

	rid_pkg::rid_state_t s_q;
	rid_pkg::rid_state_t s_d;
	rid_pkg::rid_bus_t pins;
	logic day_hit;
	logic alarm_ev;
	logic pf_rise;
	logic wr_done;
	logic rd_end;
	logic rd_hit;
	logic irq_lvl;
	logic irq_new;
	logic irq_act;
	logic [7:0] rd_mux;
	logic [7:0] flg_byte;

	// Pins gathered for the two-stage synchroniser
	assign pins = '{ce_n: mem_ce_n_in, we_n: mem_we_n_in,
		oe_n: mem_oe_n_in, addr: mem_addr_in, dq: mem_dq_in};

	// Date compare lives in its own small module
	rid_day_match i_rid_day_match (
		.day_reg_in(s_q.day),
		.cur_date_in(cur_date_in),
		.hit_out(day_hit)
	);

	// Event decode; only the second sync stage is ever looked at
	assign alarm_ev = evt_in.alarm_tick && evt_in.alarm_fields && day_hit;
	assign pf_rise = evt_in.pfail && !s_q.pf_prev;
	assign wr_done = s_q.wpend && s_q.s2.we_n && !s_q.we_prev;
	assign rd_end = s_q.s2.oe_n && !s_q.oe_prev && !s_q.s2.ce_n;

	// Flags gathered as one readable byte
	always_comb begin
		flg_byte = `RID_BYTE_ZERO;
		flg_byte[`RID_FLG_WDF] = s_q.watchdog_flag;
		flg_byte[`RID_FLG_AF] = s_q.af;
		flg_byte[`RID_FLG_PF] = s_q.pf;
	end

	// Read decode; other addresses belong to the SRAM array, not to us
	always_comb begin
		rd_hit = 1'b1;
		unique case (s_q.s2.addr)
			`RID_ADDR_CTL: rd_mux = s_q.ctl;
			`RID_ADDR_DAY: rd_mux = s_q.day;
			`RID_ADDR_FLG: rd_mux = flg_byte;
			default: begin
				rd_mux = `RID_BYTE_ZERO;
				rd_hit = 1'b0;
			end
		endcase
	end

	// Interrupt request: enabled flags in level mode, a counter in pulse mode
	assign irq_lvl = (s_q.watchdog_flag && s_q.ctl[`RID_CTL_WIE]) || // R01 R02
		(s_q.af && s_q.ctl[`RID_CTL_AIE]) || // R03 R04
		(s_q.pf && s_q.ctl[`RID_CTL_POWERFAIL_IRQ_ENABLE]); // R05
	assign irq_new = (evt_in.wdog && s_q.ctl[`RID_CTL_WIE]) ||
		(alarm_ev && s_q.ctl[`RID_CTL_AIE]) ||
		(pf_rise && s_q.ctl[`RID_CTL_POWERFAIL_IRQ_ENABLE]);
	assign irq_act = s_q.ctl[`RID_CTL_PL] ?
		(s_q.pcnt != `RID_PULSE_ZERO) : irq_lvl;

	// Pin mode: push-pull active high, or open-drain pulling low
	assign irq_pin_out = s_q.ctl[`RID_CTL_HL] && irq_act; // R07
	assign irq_pin_oe_out = s_q.ctl[`RID_CTL_HL] || irq_act; // R07

	// Data bus driven only while a selected read hits one of our bytes
	assign mem_dq_out = s_q.rd;
	assign mem_dq_oe_out = !s_q.s2.ce_n && !s_q.s2.oe_n &&
		s_q.s2.we_n && rd_hit;

	// Next state; nothing moves while the clock enable is low
	always_comb begin
		s_d = s_q;
		if (cke_in) begin
			s_d.s1 = pins;
			s_d.s2 = s_q.s1;
			s_d.we_prev = s_q.s2.we_n;
			s_d.oe_prev = s_q.s2.oe_n;
			s_d.pf_prev = evt_in.pfail;
			// Latch address and data while the write strobe is low
			if (!s_q.s2.ce_n && !s_q.s2.we_n) begin
				s_d.wa = s_q.s2.addr;
				s_d.wd = s_q.s2.dq;
				s_d.wpend = 1'b1;
			end
			// Commit at the trailing edge so the data has settled
			if (wr_done) begin
				s_d.wpend = 1'b0;
				if (s_q.wa == `RID_ADDR_CTL) begin
					s_d.ctl = s_q.wd & `RID_CTL_WMASK;
				end
				if (s_q.wa == `RID_ADDR_DAY) begin
					s_d.day = s_q.wd & `RID_DAY_WMASK; // R06
				end
			end
			// Read data and address reloaded every clock while chip enable and output enable are low
			if (!s_q.s2.ce_n && !s_q.s2.oe_n) begin
				s_d.rd = rd_mux;
				s_d.ra = s_q.s2.addr;
			end
			// Finished read of the flag byte clears it
			if (rd_end && s_q.ra == `RID_ADDR_FLG) begin
				s_d.watchdog_flag = 1'b0;
				s_d.af = 1'b0;
				s_d.pf = 1'b0;
			end
			// Events set after the clear so a colliding event survives
			if (evt_in.wdog) begin
				s_d.watchdog_flag = 1'b1; // R01 R02
			end
			if (alarm_ev) begin
				s_d.af = 1'b1; // R03 R04
			end
			if (pf_rise) begin
				s_d.pf = 1'b1; // R05
			end
			// Pulse counter reloads on every new enabled event
			if (s_q.pcnt != `RID_PULSE_ZERO) begin
				s_d.pcnt = s_q.pcnt - 8'h01;
			end
			if (irq_new) begin
				s_d.pcnt = `RID_PULSE_CYC;
			end
		end
	end

	// State register; bus stages idle high after reset
	always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
		if (!rst_n_in) begin
			s_q <= '0;
			s_q.s1.ce_n <= 1'b1;
			s_q.s1.we_n <= 1'b1;
			s_q.s1.oe_n <= 1'b1;
			s_q.s2.ce_n <= 1'b1;
			s_q.s2.we_n <= 1'b1;
			s_q.s2.oe_n <= 1'b1;
			s_q.we_prev <= 1'b1;
			s_q.oe_prev <= 1'b1;
			s_q.ctl <= `RID_CTL_RST;
			s_q.day <= `RID_DAY_RST;
		end else begin
			s_q <= s_d;
		end
	end

	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (!rst_n_in);

	property p_wdog_irq;
		(cke_in && evt_in.wdog && s_q.ctl[`RID_CTL_WIE] && !wr_done &&
			!s_q.ctl[`RID_CTL_PL]) |=> (irq_act && s_q.watchdog_flag);
	endproperty
	a_wdog_irq: assert property (p_wdog_irq) // R01
		else $error("watchdog event did not raise interrupt");

	property p_no_enable_quiet;
		(!s_q.ctl[`RID_CTL_WIE] && !s_q.ctl[`RID_CTL_AIE] &&
			!s_q.ctl[`RID_CTL_POWERFAIL_IRQ_ENABLE] && !s_q.ctl[`RID_CTL_PL]) |-> !irq_act;
	endproperty
	a_no_enable_quiet: assert property (p_no_enable_quiet) // R02
		else $error("interrupt active with all enables clear");

	property p_alarm_irq;
		(cke_in && alarm_ev && s_q.ctl[`RID_CTL_AIE] && !wr_done &&
			!s_q.ctl[`RID_CTL_PL]) |=> (irq_act && s_q.af);
	endproperty
	a_alarm_irq: assert property (p_alarm_irq) // R03
		else $error("alarm match did not raise interrupt");

	property p_alarm_flag_only;
		(cke_in && alarm_ev && !wr_done && !s_q.ctl[`RID_CTL_AIE] &&
			!s_q.ctl[`RID_CTL_PL] && !irq_new && !irq_act) |=>
			(s_q.af && !irq_act && irq_pin_oe_out == s_q.ctl[`RID_CTL_HL]);
	endproperty
	a_alarm_flag_only: assert property (p_alarm_flag_only) // R04
		else $error("disabled alarm changed the interrupt pin");

	property p_pfail;
		(cke_in && pf_rise && !wr_done && s_q.ctl[`RID_CTL_POWERFAIL_IRQ_ENABLE] &&
			!s_q.ctl[`RID_CTL_PL]) |=> (s_q.pf && irq_act);
	endproperty
	a_pfail: assert property (p_pfail) // R05
		else $error("power fail did not set flag and interrupt");

	property p_day_mask;
		(!s_q.day[`RID_DAY_MASK] &&
			cur_date_in != s_q.day[`RID_DAY_DATE_HI:0]) |-> !alarm_ev;
	endproperty
	a_day_mask: assert property (p_day_mask) // R06
		else $error("alarm fired on a different date");

	property p_pin_mode;
		s_q.ctl[`RID_CTL_HL] ? (irq_pin_oe_out && irq_pin_out == irq_act)
			: (!irq_pin_out && irq_pin_oe_out == irq_act);
	endproperty
	a_pin_mode: assert property (p_pin_mode) // R07
		else $error("interrupt pin mode mismatch");

	property p_pulse_len;
		(cke_in && irq_new && s_q.ctl[`RID_CTL_PL] && !wr_done) |=>
			(s_q.pcnt == `RID_PULSE_CYC);
	endproperty
	a_pulse_len: assert property (p_pulse_len)
		else $error("pulse counter not loaded");

	c_ctl_write: cover property (wr_done && s_q.wa == `RID_ADDR_CTL);
	c_flag_read: cover property (rd_end && s_q.ra == `RID_ADDR_FLG);
	c_irq_pulse: cover property (irq_act && s_q.ctl[`RID_CTL_PL]);
	c_open_drain: cover property (irq_act && !s_q.ctl[`RID_CTL_HL]);

endmodule : rid_top

//--- testbench/rid_host.sv
`timescale 1ns/1ps

module rid_host (
	// Clock and read data from the device
	input wire logic clk_in,
	input wire logic [7:0] dq_in,
	// Bus pins driven by the host
	output logic ce_n_out,
	output logic we_n_out,
	output logic oe_n_out,
	output logic [16:0] addr_out,
	output logic [7:0] dq_out
);
	// Idle bus: nothing selected
	initial begin
		ce_n_out = 1'b1;
		we_n_out = 1'b1;
		oe_n_out = 1'b1;
		addr_out = 17'h00000;
		dq_out = 8'h00;
	end

	// Strobes stay long because the device syncs its pins through two flops
	task wr(input logic [16:0] a, input logic [7:0] d);
		@(posedge clk_in) #1;
		{ce_n_out, we_n_out, addr_out, dq_out} = {2'b00, a, d};
		repeat (4) @(posedge clk_in);
		#1 we_n_out = 1'b1;
		repeat (2) @(posedge clk_in);
		#1 ce_n_out = 1'b1;
		dq_out = ~d; // Released data must not look held
		repeat (4) @(posedge clk_in);
	endtask : wr

	// Data is taken while output enable is still low
	task rd(input logic [16:0] a, output logic [7:0] d);
		@(posedge clk_in) #1;
		{ce_n_out, oe_n_out, addr_out} = {2'b00, a};
		repeat (5) @(posedge clk_in);
		#1 d = dq_in;
		oe_n_out = 1'b1;
		// Chip enable rises a clock later so the read counts as completed
		@(posedge clk_in) #1 ce_n_out = 1'b1;
		repeat (4) @(posedge clk_in);
	endtask : rd
endmodule : rid_host

//--- testbench/rid_top_tb.sv
`timescale 1ns/1ps
`include "rid_consts.svh"

module rid_top_tb;
	// Bench signals
	logic sys_clk_in = 1'b0;
	logic rst_n_in = 1'b0;
	rid_pkg::rid_evt_t evt = 4'h0;
	logic [5:0] date = 6'h15;
	logic ce_n, we_n, oe_n, irq, irq_oe;
	logic [16:0] addr;
	logic [7:0] dq_w, dq_r, v;
	logic dq_oe;
	logic [7:0] dq_bus;
	// Undriven data bus shows the inverse so a late drive is caught
	assign dq_bus = dq_oe ? dq_r : ~dq_r;
	int fail_count = 0;
	int comparisons = 0;

	always #20 sys_clk_in = ~sys_clk_in;

	rid_host i_rid_host (.clk_in(sys_clk_in), .dq_in(dq_bus),
		.ce_n_out(ce_n), .we_n_out(we_n), .oe_n_out(oe_n),
		.addr_out(addr), .dq_out(dq_w));

	rid_top i_rid_top (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in),
		.cke_in(1'b1), .mem_ce_n_in(ce_n), .mem_we_n_in(we_n),
		.mem_oe_n_in(oe_n), .mem_addr_in(addr), .mem_dq_in(dq_w),
		.mem_dq_out(dq_r), .mem_dq_oe_out(dq_oe), .evt_in(evt),
		.cur_date_in(date), .irq_pin_out(irq), .irq_pin_oe_out(irq_oe));

	task chk(input logic [7:0] s, input logic [7:0] e);
		comparisons++;
		if (s !== e) begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, s, e);
		end
	endtask : chk

	task report_and_stop();
		$display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
		if (fail_count == 0 && comparisons > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : report_and_stop

	// One event under a given control byte; pin pair is {out, enable}
	task ev(input logic [7:0] c, input logic [3:0] e, input logic [7:0] f,
		input logic [1:0] p);
		i_rid_host.wr(`RID_ADDR_CTL, c);
		@(posedge sys_clk_in) #1 evt = e;
		@(posedge sys_clk_in) #1 evt = 4'h0;
		@(posedge sys_clk_in) #1;
		chk({6'h00, irq, irq_oe}, {6'h00, p});
		i_rid_host.rd(`RID_ADDR_FLG, v);
		chk(v, f);
		// Flag read ends the level-mode request
		chk({6'h00, irq, irq_oe}, {7'h00, c[3]});
	endtask : ev

	// Bus drive seen in mid-read; only our own addresses may drive it
	task oe_chk(input logic [16:0] a, input logic e);
		fork
			i_rid_host.rd(a, v);
			begin
				repeat (4) @(posedge sys_clk_in);
				#1 chk({7'h00, dq_oe}, {7'h00, e});
			end
		join
	endtask : oe_chk

	// Hang guard
	initial begin
		repeat (20000) @(posedge sys_clk_in);
		fail_count++;
		report_and_stop();
	end

	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk_in);
		#1 rst_n_in = 1'b1;
		i_rid_host.rd(`RID_ADDR_CTL, v);
		chk(v, `RID_CTL_RST);
		i_rid_host.rd(`RID_ADDR_DAY, v);
		chk(v, `RID_DAY_RST);
		i_rid_host.wr(`RID_ADDR_DAY, 8'hFF);
		i_rid_host.rd(`RID_ADDR_DAY, v);
		chk(v, 8'hBF);
		i_rid_host.wr(`RID_ADDR_CTL, 8'hFF);
		i_rid_host.rd(`RID_ADDR_CTL, v);
		chk(v, 8'hEC);
		oe_chk(`RID_ADDR_DAY, 1'b1);
		oe_chk(17'h00000, 1'b0);
		$display("register test done");
		ev(8'h88, 4'h8, 8'h80, 2'b11);
		ev(8'h80, 4'h8, 8'h80, 2'b01);
		ev(8'h08, 4'h8, 8'h80, 2'b01);
		ev(8'h00, 4'h8, 8'h80, 2'b00);
		ev(8'h8C, 4'h8, 8'h80, 2'b11);
		i_rid_host.wr(`RID_ADDR_DAY, 8'h15);
		ev(8'h48, 4'h6, 8'h40, 2'b11);
		ev(8'h08, 4'h6, 8'h40, 2'b01);
		ev(8'hC8, 4'h1, 8'h20, 2'b01);
		ev(8'h28, 4'h1, 8'h20, 2'b11);
		$display("event test done");
		i_rid_host.wr(`RID_ADDR_DAY, 8'h12);
		ev(8'h48, 4'h6, 8'h00, 2'b01);
		i_rid_host.wr(`RID_ADDR_DAY, 8'h92);
		ev(8'h48, 4'h6, 8'h40, 2'b11);
		$display("day test done");
		report_and_stop();
	end
endmodule : rid_top_tb
